/* pkg/rcsbl_pkg.sv */
// constants, field layouts and types shared by the reset, strap and boot loader
package rcsbl_pkg;

    // reset sequence length in oscillator input clocks
    localparam int          RESET_SEQ_CYCLES = 750000;

    // wishbone register byte offsets
    localparam logic [7:0]  REG_STATUS    = 8'h00;
    localparam logic [7:0]  REG_PLL       = 8'h04;
    localparam logic [7:0]  REG_SECURITY  = 8'h08;
    localparam logic [7:0]  REG_CRC       = 8'h0c;
    localparam logic [7:0]  REG_LENGTH    = 8'h10;
    localparam logic [7:0]  REG_RATIO     = 8'h14;

    // pll configuration register field positions
    localparam int          PLL_RD_LSB    = 0;
    localparam int          PLL_FB_LSB    = 8;
    localparam int          PLL_OD_LSB    = 24;

    // status register field positions
    localparam int          ST_STATE_LSB  = 0;
    localparam int          ST_DONE_BIT   = 4;
    localparam int          ST_FAIL_BIT   = 5;
    localparam int          ST_OSC_INT_BIT = 6;
    localparam int          ST_SRC_LSB    = 8;
    localparam int          ST_STRAP_LSB  = 12;

    // ratio register field positions
    localparam int          RATIO_NUM_LSB = 0;
    localparam int          RATIO_DEN_LSB = 16;

    // security word bit forcing a boot from one-time-programmable memory
    localparam int          SEC_SECURE_BOOT_BIT = 5;

    // crc-32 constants and the check-word value that skips verification
    localparam logic [31:0] CRC_POLY      = 32'hedb88320;
    localparam logic [31:0] CRC_INIT      = 32'hffffffff;
    localparam logic [31:0] CRC_BYPASS    = 32'h0d15ab1e;

    // program load and entry address
    localparam int          RAM_AW        = 16;
    localparam logic [15:0] RAM_BASE      = 16'h0000;
    localparam logic [31:0] OTP_BASE      = 32'h00000000;

    typedef struct packed {
        logic [2:0]  od;   // output divider
        logic [11:0] fb;   // feedback value
        logic [5:0]  rd;   // reference divider
    } rcsbl_pll_t;

    // strap-selected boot settings, indexed by pll strap bits [1:0]
    localparam rcsbl_pll_t PLL_STRAP_00 = '{od: 3'h1, fb: 12'h07a, rd: 6'h00};
    localparam rcsbl_pll_t PLL_STRAP_01 = '{od: 3'h2, fb: 12'h017, rd: 6'h00};
    localparam rcsbl_pll_t PLL_STRAP_10 = '{od: 3'h2, fb: 12'h031, rd: 6'h00};
    localparam rcsbl_pll_t PLL_STRAP_11 = '{od: 3'h2, fb: 12'h077, rd: 6'h00};

    typedef struct packed {
        logic              we;
        logic [RAM_AW-1:0] addr;  // word address
        logic [31:0]       data;
    } rcsbl_ram_wr_t;

    typedef enum logic [2:0] {
        SRC_JTAG = 3'h0,
        SRC_RSVD = 3'h1,
        SRC_LINK = 3'h2,
        SRC_SPI  = 3'h3,
        SRC_OTP  = 3'h4
    } rcsbl_src_t;

    // gray-coded along hold, sequence, length, program, check, run
    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_SEQ  = 3'b001,
        ST_LEN  = 3'b011,
        ST_PROG = 3'b010,
        ST_CHK  = 3'b110,
        ST_RUN  = 3'b111,
        ST_FAIL = 3'b101,
        ST_WAIT = 3'b100
    } rcsbl_state_t;

endpackage

/* hw/rcsbl_crc.sv */
// byte-serial reflected crc-32 engine
`timescale 1ns/1ps
module rcsbl_crc
    import rcsbl_pkg::*;
(
    input  wire logic        clk_i,   // system clock
    input  wire logic        rst_i,   // synchronous reset, active high
    input  wire logic        init_i,  // preload the register
    input  wire logic        en_i,    // absorb one byte
    input  wire logic [7:0]  byte_i,  // byte, least significant bit first
    output logic      [31:0] crc_o    // running register, not inverted
);
    logic [31:0] crc_d;

    // eight reflected shift steps per byte
    always_comb begin
        crc_d = crc_o ^ {24'h000000, byte_i};
        for (int i = 0; i < 8; i++) begin
            crc_d = crc_d[0] ? ((crc_d >> 1) ^ CRC_POLY) : (crc_d >> 1);
        end
    end

    // init wins over a byte so a new image never inherits old residue
    always_ff @(posedge clk_i) begin
        if (rst_i || init_i) begin
            crc_o <= CRC_INIT;
        end else if (en_i) begin
            crc_o <= crc_d;
        end
    end
endmodule

/* hw/rcsbl_top.sv */
// reset release, strap sampling, pll setup and boot image loader
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
// Behaviour
// - while chip reset pin is low, all gpio output enables stay off.
// - after release, count the reset sequence, then enable pulls and boot.
// - boot pll setting comes from strap bits 1:0; software may rewrite it.
// - straps 00 load od1 f122 r0; straps 11 load od2 f119 r0.
// - straps 10 load od2 f49 r0; straps 01 load od2 f23 r0.
// - core clock is osc times (f+1)/2 over (r+1) and (od+1).
// - pll divider fields are writable at run time through a register.
// - straps 3:2 choose jtag wait, reserved, link b or spi flash.
// - secure-boot bit 5 overrides boot source straps 3:2 and boots from otp.
// - image is length word, four times length bytes, then check word.
// - check word 0x0d15ab1e skips crc verification.
// - length and check words arrive least significant byte first.
// - program stored from lowest ram address; execution starts there.
// - crc covers length word and program bytes, not the check word.
// - crc uses 0xedb88320, preload all ones, inverted residue compared.
// - low oscillator select pin picks resonator, high picks internal 20 mhz.
// - secure boot reads the otp image from address zero.
module rcsbl_top
    import rcsbl_pkg::*;
#(
    parameter int GPIO_W     = 32,               // general-purpose pin count
    parameter int SEQ_CYCLES = RESET_SEQ_CYCLES  // reset sequence length
) (
    input  wire logic              clk_i,                   // oscillator input clock
    input  wire logic              rst_i,                   // synchronous reset, active high
    input  wire logic              chip_rst_n_i,            // chip reset pin, active low
    input  wire logic [3:0]        strap_i,                 // [1:0] pll straps, [3:2] boot source
    input  wire logic              osc_source_select_low_i, // oscillator select pin
    input  wire logic [31:0]       security_i,              // security word from otp
    input  wire logic              img_valid_i,             // image byte valid
    input  wire logic [7:0]        img_data_i,              // image byte
    output logic                   img_ready_o,             // image byte accepted
    output rcsbl_src_t             boot_src_o,              // active boot source
    output logic [31:0]            img_addr_o,              // byte address of next image byte
    output logic [GPIO_W-1:0]      gpio_oe_o,               // gpio output enables
    output logic [GPIO_W-1:0]      gpio_pull_en_o,          // gpio pull resistor enables
    output logic                   boot_clk_int_o,          // 1 selects internal 20 mhz osc
    output rcsbl_pll_t             pll_cfg_o,               // pll divider fields
    output logic [12:0]            core_clk_num_o,          // core clock ratio numerator
    output logic [10:0]            core_clk_den_o,          // core clock ratio denominator
    output rcsbl_ram_wr_t          ram_wr_o,                // program ram write port
    output logic                   core_run_o,              // core released to execute
    output logic [RAM_AW-1:0]      core_pc_o,               // execution start address
    output logic                   boot_fail_o,             // image check failed
    input  wire logic              wb_cyc_i,                // wishbone cycle
    input  wire logic              wb_stb_i,                // wishbone strobe
    input  wire logic              wb_we_i,                 // wishbone write enable
    input  wire logic [7:0]        wb_adr_i,                // wishbone byte address
    input  wire logic [3:0]        wb_sel_i,                // wishbone byte selects
    input  wire logic [31:0]       wb_dat_i,                // wishbone write data
    output logic [31:0]            wb_dat_o,                // wishbone read data
    output logic                   wb_ack_o                 // wishbone acknowledge
);
    rcsbl_state_t      state_q, state_d;
    logic [19:0]       seq_cnt_q;
    logic [31:0]       word_q;
    logic [1:0]        byte_cnt_q;
    logic [31:0]       len_q;
    logic [31:0]       words_left_q;
    logic [31:0]       security_q;
    logic [31:0]       crc_reg;
    logic [31:0]       crc_final_q;
    logic              take;
    logic              word_done;
    logic [31:0]       word_full;
    logic              seq_done;
    logic              wb_req;
    logic [31:0]       pll_word;
    logic [31:0]       rd_data;

    assign take      = img_valid_i && img_ready_o;
    assign word_done = take && (byte_cnt_q == 2'd3);
    assign word_full = {img_data_i, word_q[31:8]};
    assign seq_done  = (seq_cnt_q == 20'(SEQ_CYCLES - 1));
    assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // boot sequence transitions
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_HOLD: state_d = ST_SEQ;
            ST_SEQ: begin
                if (seq_done) begin
                    if (security_i[SEC_SECURE_BOOT_BIT] || strap_i[3]) begin
                        state_d = ST_LEN;
                    end else begin
                        state_d = ST_WAIT;
                    end
                end
            end
            ST_LEN: begin
                if (word_done) begin
                    state_d = (word_full == 32'h0) ? ST_CHK : ST_PROG;
                end
            end
            ST_PROG: begin
                if (word_done && words_left_q == 32'h1) begin
                    state_d = ST_CHK;
                end
            end
            ST_CHK: begin
                if (word_done) begin
                    if (word_full == CRC_BYPASS || word_full == ~crc_reg) begin
                        state_d = ST_RUN;
                    end else begin
                        state_d = ST_FAIL;
                    end
                end
            end
            ST_RUN:  state_d = ST_RUN;
            ST_FAIL: state_d = ST_FAIL;
            ST_WAIT: state_d = ST_WAIT;
        endcase
        if (!chip_rst_n_i) begin
            state_d = ST_HOLD;
        end
    end

    // state register; the chip reset pin restarts the whole sequence
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    // reset sequence counter runs only after the reset pin is released
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q != ST_SEQ) begin
            seq_cnt_q <= 20'h0;
        end else if (!seq_done) begin
            seq_cnt_q <= seq_cnt_q + 20'h1;
        end
    end

    // gpio drive and pulls: block never drives pins, pulls come on after the sequence
    always_ff @(posedge clk_i) begin
        if (rst_i || !chip_rst_n_i) begin
            gpio_oe_o      <= '0;
            gpio_pull_en_o <= '0;
        end else begin
            gpio_oe_o      <= '0;
            gpio_pull_en_o <= {GPIO_W{state_d != ST_HOLD && state_d != ST_SEQ}};
        end
    end

    // straps and security word are sampled once, as the sequence ends
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_src_o     <= SRC_JTAG;
            security_q     <= 32'h0;
            boot_clk_int_o <= 1'b0;
        end else begin
            boot_clk_int_o <= osc_source_select_low_i;
            if (state_q == ST_SEQ && seq_done) begin
                security_q <= security_i;
                if (security_i[SEC_SECURE_BOOT_BIT]) begin
                    boot_src_o <= SRC_OTP;
                end else begin
                    boot_src_o <= rcsbl_src_t'({1'b0, strap_i[3:2]});
                end
            end
        end
    end

    // pll fields: strap table at boot, byte-lane writes by software afterwards
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pll_cfg_o <= PLL_STRAP_00;
        end else if (state_q == ST_SEQ && seq_done) begin
            unique case (strap_i[1:0])
                2'b00: pll_cfg_o <= PLL_STRAP_00;
                2'b11: pll_cfg_o <= PLL_STRAP_11;
                2'b10: pll_cfg_o <= PLL_STRAP_10;
                2'b01: pll_cfg_o <= PLL_STRAP_01;
            endcase
        end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == REG_PLL) begin
            // range checks are left to software; any field value is accepted
            if (wb_sel_i[0]) pll_cfg_o.rd        <= wb_dat_i[PLL_RD_LSB +: 6];
            if (wb_sel_i[1]) pll_cfg_o.fb[7:0]   <= wb_dat_i[PLL_FB_LSB +: 8];
            if (wb_sel_i[2]) pll_cfg_o.fb[11:8]  <= wb_dat_i[PLL_FB_LSB + 8 +: 4];
            if (wb_sel_i[3]) pll_cfg_o.od        <= wb_dat_i[PLL_OD_LSB +: 3];
        end
    end

    // core clock ratio, one cycle behind the pll fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_clk_num_o <= 13'h1;
            core_clk_den_o <= 11'h2;
        end else begin
            core_clk_num_o <= 13'({1'b0, pll_cfg_o.fb} + 13'h1);
            core_clk_den_o <= 11'(({5'h0, pll_cfg_o.rd} + 11'h1) * ({8'h0, pll_cfg_o.od} + 11'h1) * 11'h2);
        end
    end

    // byte assembly, least significant byte first
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q == ST_SEQ) begin
            word_q     <= 32'h0;
            byte_cnt_q <= 2'd0;
            img_addr_o <= OTP_BASE;
        end else if (take) begin
            word_q     <= word_full;
            byte_cnt_q <= byte_cnt_q + 2'd1;
            img_addr_o <= img_addr_o + 32'h1;
        end
    end

    // ready follows the next state so no byte is taken after the check word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            img_ready_o <= 1'b0;
        end else begin
            img_ready_o <= (state_d == ST_LEN || state_d == ST_PROG || state_d == ST_CHK);
        end
    end

    // length capture and program word counting
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q == ST_SEQ) begin
            len_q        <= 32'h0;
            words_left_q <= 32'h0;
        end else if (word_done && state_q == ST_LEN) begin
            len_q        <= word_full;
            words_left_q <= word_full;
        end else if (word_done && state_q == ST_PROG) begin
            words_left_q <= words_left_q - 32'h1;
        end
    end

    // program words go to ram from the lowest address upward
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q == ST_SEQ) begin
            ram_wr_o <= '{we: 1'b0, addr: RAM_BASE, data: 32'h0};
        end else begin
            ram_wr_o.we <= word_done && state_q == ST_PROG;
            if (ram_wr_o.we) begin
                ram_wr_o.addr <= ram_wr_o.addr + RAM_AW'(1);
            end
            if (word_done) begin
                ram_wr_o.data <= word_full;
            end
        end
    end

    // crc runs over length and program bytes only
    rcsbl_crc u_crc (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .init_i (state_q == ST_SEQ),
        .en_i   (take && (state_q == ST_LEN || state_q == ST_PROG)),
        .byte_i (img_data_i),
        .crc_o  (crc_reg)
    );

    // run or fail outcome; entry address is always the load base
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q == ST_SEQ) begin
            core_run_o  <= 1'b0;
            boot_fail_o <= 1'b0;
            core_pc_o   <= RAM_BASE;
            crc_final_q <= 32'h0;
        end else begin
            core_pc_o   <= RAM_BASE;
            core_run_o  <= (state_d == ST_RUN);
            boot_fail_o <= (state_d == ST_FAIL);
            if (state_q == ST_CHK && word_done) begin
                crc_final_q <= ~crc_reg;
            end
        end
    end

    // register read mux; unmapped offsets read zero
    assign pll_word = (32'(pll_cfg_o.rd) << PLL_RD_LSB) | (32'(pll_cfg_o.fb) << PLL_FB_LSB)
                    | (32'(pll_cfg_o.od) << PLL_OD_LSB);
    always_comb begin
        unique case (wb_adr_i)
            REG_STATUS:   rd_data = (32'(state_q) << ST_STATE_LSB) | (32'(core_run_o) << ST_DONE_BIT)
                                  | (32'(boot_fail_o) << ST_FAIL_BIT) | (32'(boot_clk_int_o) << ST_OSC_INT_BIT)
                                  | (32'(boot_src_o) << ST_SRC_LSB) | (32'(strap_i) << ST_STRAP_LSB);
            REG_PLL:      rd_data = pll_word;
            REG_SECURITY: rd_data = security_q;
            REG_CRC:      rd_data = crc_final_q;
            REG_LENGTH:   rd_data = len_q;
            REG_RATIO:    rd_data = (32'(core_clk_num_o) << RATIO_NUM_LSB) | (32'(core_clk_den_o) << RATIO_DEN_LSB);
            default:      rd_data = 32'h0;
        endcase
    end

    // single-wait-state wishbone slave: ack one cycle after the request, then drop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end
endmodule

/* tb/rcsbl_monitor.sv */
// concurrent checks on the reset, strap and boot loader ports
`timescale 1ns/1ps
module rcsbl_monitor
    import rcsbl_pkg::*;
#(
    parameter int GPIO_W = 32  // general-purpose pin count
) (
    input  wire logic          clk_i,                   // oscillator clock
    input  wire logic          rst_i,                   // synchronous reset
    input  wire logic          chip_rst_n_i,            // chip reset pin
    input  wire logic          osc_source_select_low_i, // oscillator select pin
    input  wire logic          img_valid_i,             // image byte valid
    input  wire logic          img_ready_o,             // image byte accepted
    input  wire logic [31:0]   img_addr_o,              // next image byte address
    input  wire logic [GPIO_W-1:0] gpio_oe_o,           // gpio output enables
    input  wire logic [GPIO_W-1:0] gpio_pull_en_o,      // gpio pull enables
    input  wire logic          boot_clk_int_o,          // internal osc chosen
    input  wire rcsbl_pll_t    pll_cfg_o,               // pll divider fields
    input  wire logic [12:0]   core_clk_num_o,          // ratio numerator
    input  wire logic [10:0]   core_clk_den_o,          // ratio denominator
    input  wire logic          core_run_o,              // core released
    input  wire logic [RAM_AW-1:0] core_pc_o,           // start address
    input  wire logic          boot_fail_o,             // image check failed
    input  wire logic          wb_cyc_i,                // wishbone cycle
    input  wire logic          wb_stb_i,                // wishbone strobe
    input  wire logic          wb_ack_o                 // wishbone acknowledge
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    oe_tristate_a: assert property (gpio_oe_o == '0)
        else $error("gpio output enable raised");
    hold_pulls_off_a: assert property (!chip_rst_n_i |=> gpio_pull_en_o == '0 && !img_ready_o)
        else $error("pulls or ready active in chip reset");
    osc_select_a: assert property (!$past(rst_i) |-> boot_clk_int_o == $past(osc_source_select_low_i))
        else $error("boot clock select not following pin");
    clk_ratio_a: assert property (!rst_i && $stable(pll_cfg_o) ##1 $stable(pll_cfg_o) |->
        core_clk_num_o == 13'(pll_cfg_o.fb) + 13'h1 &&
        core_clk_den_o == 11'(2 * (pll_cfg_o.rd + 1) * (pll_cfg_o.od + 1)))
        else $error("core clock ratio wrong");
    byte_count_a: assert property (img_valid_i && img_ready_o |=> img_addr_o == $past(img_addr_o) + 32'h1)
        else $error("image address not advanced");
    entry_pc_a: assert property (core_run_o |-> core_pc_o == RAM_BASE && !boot_fail_o)
        else $error("bad entry or run with failure");
    done_ready_a: assert property ($rose(core_run_o) || $rose(boot_fail_o) |-> !img_ready_o)
        else $error("ready still high after check word");
    run_hold_a: assert property (core_run_o && chip_rst_n_i |=> core_run_o)
        else $error("core run dropped");
    reg_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("register ack not a single pulse");
endmodule

bind rcsbl_top rcsbl_monitor #(.GPIO_W(GPIO_W)) u_rcsbl_monitor (.*);

/* tb/rcsbl_src_model.sv */
// byte-serial boot image source standing in for flash or link peer
`timescale 1ns/1ps
module rcsbl_src_model (
    input  wire logic       clk_i,   // system clock
    input  wire logic       rst_i,   // synchronous reset, active high
    input  wire logic       ready_i, // loader takes the byte
    input  wire logic [6:0] stall_i, // percent of cycles left idle
    output logic            valid_o, // byte offered
    output logic [7:0]      data_o   // offered byte
);
    logic [7:0] q[$];

    // bench loads image bytes in wire order
    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask

    // hold an offered byte until taken; idle data toggles so a stale byte never repeats
    always @(posedge clk_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
            data_o  <= 8'h5a;
            q.delete();
        end else if (!valid_o || ready_i) begin
            if (q.size() != 0 && $urandom_range(99) >= stall_i) begin
                valid_o <= 1'b1;
                data_o  <= q.pop_front();
            end else begin
                valid_o <= 1'b0;
                data_o  <= ~data_o;
            end
        end
    end
endmodule

/* tb/tb.sv */
// self-checking bench for the reset, strap and boot loader
`timescale 1ns/1ps
module tb;
    import rcsbl_pkg::*;
    localparam int SEQ = 16;
    logic          clk_i, rst_i, chip_rst_n, osc_sel, img_valid, img_ready, cyc, stb, we, ack, run, fail, clk_int;
    logic [3:0]    strap, sel;
    logic [7:0]    img_data, adr;
    logic [6:0]    stall;
    logic [31:0]   security, img_addr, wdat, rdat, oe, pull;
    rcsbl_src_t    src;
    rcsbl_pll_t    pll;
    logic [12:0]   num;
    logic [10:0]   den;
    rcsbl_ram_wr_t ram_wr;
    logic [15:0]   pc;
    int            n_mismatch = 0, cmp_count = 0, wr_idx = 0;
    logic [31:0]   exp_w[$];

    rcsbl_top #(.SEQ_CYCLES(SEQ)) u_rcsbl_top (.clk_i(clk_i), .rst_i(rst_i), .chip_rst_n_i(chip_rst_n),
        .strap_i(strap), .osc_source_select_low_i(osc_sel), .security_i(security), .img_valid_i(img_valid),
        .img_data_i(img_data), .img_ready_o(img_ready), .boot_src_o(src), .img_addr_o(img_addr),
        .gpio_oe_o(oe), .gpio_pull_en_o(pull), .boot_clk_int_o(clk_int), .pll_cfg_o(pll),
        .core_clk_num_o(num), .core_clk_den_o(den), .ram_wr_o(ram_wr), .core_run_o(run), .core_pc_o(pc),
        .boot_fail_o(fail), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
    rcsbl_src_model u_rcsbl_src_model (.clk_i(clk_i), .rst_i(rst_i), .ready_i(img_ready), .stall_i(stall),
        .valid_o(img_valid), .data_o(img_data));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // reflected crc step, one byte lsb first
    function automatic logic [31:0] crc_b(input logic [31:0] c, input logic [7:0] b);
        c = c ^ {24'h0, b};
        for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        return c;
    endfunction

    function automatic rcsbl_pll_t exp_pll(input logic [1:0] s);
        case (s)
            2'b00: return '{3'h1, 12'h07a, 6'h00};
            2'b11: return '{3'h2, 12'h077, 6'h00};
            2'b10: return '{3'h2, 12'h031, 6'h00};
            default: return '{3'h2, 12'h017, 6'h00};
        endcase
    endfunction

    // classic single cycle; data taken at the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r);
        int n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
        do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
        if (n >= 20) chk("wb_ack", 1, 0);
        r = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk_i);
    endtask

    // ram writes land in order from the lowest address
    always @(posedge clk_i) begin
        if (!rst_i && ram_wr.we === 1'b1) begin
            chk("ram_addr", 32'(RAM_BASE) + wr_idx, 32'(ram_wr.addr));
            chk("ram_data", exp_w[wr_idx], ram_wr.data);
            wr_idx++;
        end
    end

    // mode 0 good crc, 1 bypass word, 2 corrupted crc
    task automatic boot(input logic [3:0] st, input logic sec, input int mode);
        logic [31:0] c, len, w;
        rcsbl_pll_t  p;
        int          n;
        strap <= st;
        security <= ($urandom() & 32'hffffffdf) | (32'(sec) << 5);
        osc_sel <= 1'($urandom_range(1));
        stall <= 7'($urandom_range(60));
        chip_rst_n <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("pull_hold", 0, pull);
        chip_rst_n <= 1'b1;
        n = 0;
        while (pull !== '1 && n < SEQ + 20) begin @(posedge clk_i); n++; end
        chk("seq_len", 1, 32'(n >= SEQ && n < SEQ + 20));
        repeat (2) @(posedge clk_i);
        p = exp_pll(st[1:0]);
        chk("pll", 32'(p), 32'(pll));
        chk("ratio", {3'h0, 13'(p.fb) + 13'h1, 5'h0, 11'(2 * (p.od + 1))}, {3'h0, num, 5'h0, den});
        chk("src", sec ? 32'(SRC_OTP) : {30'h0, st[3:2]}, 32'(src));
        chk("img_addr0", 0, img_addr);
        if (!sec && !st[3]) begin
            chk("wait_ready", 0, 32'(img_ready));
        end else begin
            len = 32'($urandom_range(4));
            exp_w.delete();
            wr_idx = 0;
            c = 32'hffffffff;
            for (int i = 0; i <= len; i++) begin
                w = i == 0 ? len : $urandom();
                if (i > 0) exp_w.push_back(w);
                for (int k = 0; k < 4; k++) begin
                    u_rcsbl_src_model.push(w[8*k+:8]);
                    c = crc_b(c, w[8*k+:8]);
                end
            end
            c = mode == 1 ? 32'h0d15ab1e : mode == 2 ? ~c ^ 32'h1 : ~c;
            for (int k = 0; k < 4; k++) u_rcsbl_src_model.push(c[8*k+:8]);
            n = 0;
            while (run !== 1'b1 && fail !== 1'b1 && n < 500) begin @(posedge clk_i); n++; end
            @(posedge clk_i);
            chk("run", 32'(mode != 2), 32'(run));
            chk("fail", 32'(mode == 2), 32'(fail));
            chk("words", len, wr_idx);
            chk("bytes", 4 * len + 8, img_addr);
            chk("pc", 0, 32'(pc));
        end
        $display("boot test strap %h secure %0d mode %0d done", st, sec, mode);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        #500000;
        n_mismatch++;
        end_sim();
    end

    initial begin
        logic [31:0] w, r;
        rst_i = 1'b1;
        chip_rst_n = 1'b1;
        {strap, osc_sel, security, stall, cyc, stb, we, adr, sel, wdat} = '0;
        void'($urandom(69));
        repeat (5) @(posedge clk_i);
        chk("oe_reset", 0, oe);
        rst_i <= 1'b0;
        for (int s = 0; s < 16; s++) boot(4'(s), 1'b0, s % 3);
        boot(4'h1, 1'b1, 0);
        boot(4'h2, 1'b1, 1);
        // pll retune after boot, fields in range
        for (int i = 0; i < 4; i++) begin
            w = {5'h0, 3'($urandom_range(7)), 4'h0, 12'($urandom_range(4095)), 2'h0, 6'($urandom_range(63))};
            wb(1'b1, REG_PLL, w, 4'hf, r);
            wb(1'b0, REG_PLL, 32'h0, 4'hf, r);
            chk("pll_reg", w, r);
            chk("pll_out", {w[26:24], w[19:8], w[5:0]}, 32'(pll));
        end
        wb(1'b1, REG_PLL, 32'hffffffff, 4'h1, r);
        wb(1'b0, REG_PLL, 32'h0, 4'hf, r);
        chk("pll_sel", {w[31:6], 6'h3f}, r);
        wb(1'b0, 8'h3c, 32'h0, 4'hf, r);
        chk("unmapped", 0, r);
        wb(1'b0, REG_STATUS, 32'h0, 4'hf, r);
        chk("status_run", 1, 32'(r[ST_DONE_BIT]));
        $display("register test done");
        end_sim();
    end
endmodule
